// File: prat_bridge.sv
// Core to peripheral register access sequencer.
// Assumes core request and transfer-controller request come from ref_clk logic,
// and that the core holds its request until acknowledged.
// Operation
// - Access cycles: main plus sync plus peripheral
// - Sync only for buses 2-6, external control
// - Main plus sync within one peripheral cycle
// - Next access starts core cycle after completion
// - Transfer controller contention adds cycles
`default_nettype none

module prat_bridge #(
  parameter int                                              PCLK_DIV = prat_pkg::PCLK_DIV_DEF,
  parameter logic [prat_pkg::BUS_N-1:0][prat_pkg::CNT_W-1:0] BUS_CYC  = prat_pkg::BUS_CYC_DEF
) (
  input  wire logic                          ref_clk,
  input  wire logic                          srst,
  input  wire logic                          core_req,
  input  wire logic                          core_we,
  input  wire logic [prat_pkg::ADDR_W-1:0]   core_addr,
  input  wire logic [prat_pkg::DATA_W-1:0]   core_wdata,
  output logic                               core_wait,
  output logic                               core_ack,
  output logic [prat_pkg::DATA_W-1:0]        core_rdata,
  input  wire logic                          xfer_req,
  output logic [prat_pkg::IDX_W-1:0]         per_bus,
  output logic [prat_pkg::ADDR_W-1:0]        per_addr,
  output logic [prat_pkg::DATA_W-1:0]        per_wdata,
  output logic                               per_we,
  output logic                               per_stb,
  input  wire logic [prat_pkg::DATA_W-1:0]   per_rdata
);
  import prat_pkg::*;

  typedef struct packed {
    prat_state_type     state;
    logic [CNT_W-1:0]   cnt;
    logic               sync;
    logic [IDX_W-1:0]   bus;
    logic [ADDR_W-1:0]  addr;
    logic [DATA_W-1:0]  wdata;
    logic               we;
    logic [DATA_W-1:0]  rdata;
    // len, span and stalled feed only the timing checks
    logic [CNT_W-1:0]   len;
    logic [7:0]         span;
    logic               stalled;
  } prat_seq_state_type;

  prat_seq_state_type st_reg;
  prat_seq_state_type st_next;
  logic               tick;

  prat_dec_if dif ();

  prat_decode #(
    .PCLK_DIV (PCLK_DIV),
    .BUS_CYC  (BUS_CYC)
  ) u_decode (
    .ref_clk (ref_clk),
    .srst    (srst),
    .dec     (dif)
  );

  assign dif.addr = core_addr;

  // Synced buses and external control count peripheral cycles, the rest of bus 1 counts core cycles
  assign tick = st_reg.sync ? dif.pclk_en : 1'b1;

  always_comb begin
    st_next = st_reg;
    // Cost of the running access; restarts whenever the sequencer idles
    if (st_reg.state == PRAT_IDLE) begin
      st_next.span    = 8'h00;
      st_next.stalled = 1'b0;
    end else begin
      st_next.span    = st_reg.span + 8'h01;
      st_next.stalled = st_reg.stalled || xfer_req;
    end
    unique case (st_reg.state)
      PRAT_IDLE: begin
        // Transfer controller owns the bus: hold off the core
        if (core_req && !xfer_req) begin
          st_next.state = PRAT_MAIN;
          st_next.bus   = dif.bus_idx;
          st_next.sync  = dif.need_sync;
          st_next.cnt   = dif.bus_cyc;
          st_next.len   = dif.bus_cyc;
          st_next.addr  = core_addr;
          st_next.wdata = core_wdata;
          st_next.we    = core_we;
        end
      end
      PRAT_MAIN: begin
        // Leaving on the enable keeps main plus sync inside one slow cycle
        if (!st_reg.sync || dif.pclk_en) begin
          st_next.state = PRAT_PBUS;
        end else begin
          st_next.state = PRAT_SYNC;
        end
      end
      PRAT_SYNC: begin
        if (dif.pclk_en) begin
          st_next.state = PRAT_PBUS;
        end
      end
      PRAT_PBUS: begin
        if (tick && !xfer_req) begin
          if (st_reg.cnt <= CNT_W'(1)) begin
            st_next.state = PRAT_STRB;
          end else begin
            st_next.cnt = st_reg.cnt - CNT_W'(1);
          end
        end
      end
      PRAT_STRB: begin
        st_next.state = PRAT_DONE;
        if (!st_reg.we) begin
          st_next.rdata = per_rdata;
        end
      end
      PRAT_DONE: begin
        st_next.state = PRAT_IDLE;
      end
      default: begin
        st_next.state = PRAT_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign core_wait  = core_req && (st_reg.state != PRAT_DONE);
  assign core_ack   = (st_reg.state == PRAT_DONE);
  assign core_rdata = st_reg.rdata;
  assign per_bus    = st_reg.bus;
  assign per_addr   = st_reg.addr;
  assign per_wdata  = st_reg.wdata;
  assign per_we     = st_reg.we;
  assign per_stb    = (st_reg.state == PRAT_STRB);

  localparam int SYNC_MAX = PCLK_DIV;

  // Synced access cost: bus cycles stretched by the divider, plus main/sync and strobe
  logic [7:0] span_floor;
  logic [7:0] span_cap;
  assign span_floor = (8'(st_reg.len) * 8'(PCLK_DIV)) + 8'h02;
  assign span_cap   = (8'(st_reg.len) * 8'(PCLK_DIV)) + 8'(PCLK_DIV) + 8'h01;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);

  sequence main_phase;
    st_reg.state == PRAT_MAIN;
  endsequence

  sequence strobe_then_ack;
    per_stb ##1 core_ack ##1 (st_reg.state == PRAT_IDLE);
  endsequence

  // Contended accesses may take longer, so only clean ones are timed
  sequence acked_clean;
    core_ack && !st_reg.stalled;
  endsequence

  sync_bound_a: assert property (main_phase |-> ##[1:SYNC_MAX] (st_reg.state == PRAT_PBUS))
    else $error("main plus sync exceeded one peripheral cycle");

  no_sync_a: assert property (main_phase ##0 !st_reg.sync |=> st_reg.state == PRAT_PBUS)
    else $error("sync cycles inserted on unsynced bus");

  bus_count_a: assert property ((st_reg.state == PRAT_PBUS) && !st_reg.sync && !xfer_req
      && (st_reg.cnt == CNT_W'(1)) |=> per_stb)
    else $error("peripheral bus count not honoured");

  xfer_hold_a: assert property ((st_reg.state == PRAT_IDLE) && xfer_req
      |=> st_reg.state == PRAT_IDLE)
    else $error("access started during transfer controller contention");

  xfer_stall_a: assert property ((st_reg.state == PRAT_PBUS) && xfer_req
      |=> (st_reg.state == PRAT_PBUS) && $stable(st_reg.cnt))
    else $error("peripheral count advanced under contention");

  sync_tick_a: assert property ((st_reg.state == PRAT_PBUS) && st_reg.sync && !dif.pclk_en
      |=> $stable(st_reg.cnt))
    else $error("synced count moved between peripheral cycles");

  span_fast_a: assert property (acked_clean ##0 !st_reg.sync
      |-> st_reg.span == 8'(st_reg.len) + 8'h02)
    else $error("unsynced access cost is not main plus bus cycles");

  span_slow_a: assert property (acked_clean ##0 st_reg.sync
      |-> (st_reg.span >= span_floor) && (st_reg.span <= span_cap))
    else $error("synced access cost outside one slow cycle of sync");

  ack_pulse_a: assert property (core_ack |=> !core_ack)
    else $error("ack lasted more than one cycle");

  write_keep_a: assert property (per_stb && per_we |=> $stable(core_rdata))
    else $error("write disturbed returned read data");

  ack_order_a: assert property (per_stb |-> strobe_then_ack)
    else $error("ack not one cycle after strobe");

  wait_hold_a: assert property (core_req && (st_reg.state == PRAT_PBUS) |-> core_wait && !core_ack)
    else $error("core released before access finished");

  read_data_a: assert property (per_stb && !per_we |=> core_rdata == $past(per_rdata))
    else $error("read data not returned");

endmodule : prat_bridge

`default_nettype wire

// File: prat_dec_if.sv
// Carrier between the access sequencer and its decoder/divider.
// Assumes both ends sit on ref_clk.
`default_nettype none

interface prat_dec_if;
  import prat_pkg::*;
  logic [ADDR_W-1:0] addr;
  logic [IDX_W-1:0]  bus_idx;
  logic              need_sync;
  logic [CNT_W-1:0]  bus_cyc;
  logic              pclk_en;

  modport dec (input addr, output bus_idx, output need_sync, output bus_cyc, output pclk_en);
  modport seq (output addr, input bus_idx, input need_sync, input bus_cyc, input pclk_en);
endinterface : prat_dec_if

`default_nettype wire

// File: prat_decode.sv
// Address decoder and peripheral clock enable divider.
// Assumes addr is stable from logic on ref_clk.
`default_nettype none

module prat_decode #(
  parameter int                                              PCLK_DIV = prat_pkg::PCLK_DIV_DEF,
  parameter logic [prat_pkg::BUS_N-1:0][prat_pkg::CNT_W-1:0] BUS_CYC  = prat_pkg::BUS_CYC_DEF
) (
  input  wire logic ref_clk,
  input  wire logic srst,
  prat_dec_if.dec   dec
);
  import prat_pkg::*;

  typedef struct packed {
    logic [7:0] div_cnt;
  } prat_dec_state_type;

  prat_dec_state_type st_reg;
  prat_dec_state_type st_next;
  logic               in_io;
  logic [IDX_W-1:0]   idx;
  logic               ext_ctl;

  localparam logic [7:0] DIV_LAST = 8'(PCLK_DIV - 1);

  always_comb begin
    st_next = st_reg;
    if (st_reg.div_cnt == DIV_LAST) begin
      st_next.div_cnt = 8'h00;
    end else begin
      st_next.div_cnt = st_reg.div_cnt + 8'h01;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // Unmapped addresses fall on bus 1 so the core never hangs
  assign in_io = (dec.addr[31:20] == IO_TOP) && (dec.addr[19:16] >= BUS1_PAGE)
                 && (dec.addr[19:16] <= BUS6_PAGE);
  assign idx   = in_io ? IDX_W'(dec.addr[19:16] - PAGE_TO_IDX) : IDX_W'(1);
  // External bus control needs sync, its bus error block does not
  assign ext_ctl = in_io && (dec.addr[19:12] == EXTBUS_PAGE) && (dec.addr[11:4] != BERR_LINE);

  assign dec.bus_idx   = idx;
  assign dec.need_sync = (idx != IDX_W'(1)) || ext_ctl;
  assign dec.bus_cyc   = BUS_CYC[idx - IDX_W'(1)];
  assign dec.pclk_en   = (st_reg.div_cnt == DIV_LAST);

endmodule : prat_decode

`default_nettype wire

// File: prat_per_model.sv
// Peripheral-side responder for the register access bench.
// Assumes per_rdata is sampled combinationally in the strobe cycle.
`default_nettype none

module prat_per_model (
  input  wire logic        ref_clk,
  input  wire logic        per_stb,
  input  wire logic        per_we,
  input  wire logic [31:0] per_addr,
  input  wire logic [31:0] per_wdata,
  output logic      [31:0] per_rdata,
  output logic      [31:0] seen_addr,
  output logic             seen_we
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] mem_addr_reg = 32'hffff_ffff;
  logic [31:0] mem_data_reg = 32'h0;
  logic [31:0] junk_reg     = 32'h0;

  // Off-strobe data churns, so a sample outside the strobe cannot match
  assign per_rdata = !per_stb ? junk_reg :
    (per_addr == mem_addr_reg) ? mem_data_reg : per_addr ^ 32'h5a5a_5a5a;

  always @(posedge ref_clk) begin
    junk_reg <= junk_reg + 32'h1357_9bdf;
    if (per_stb) begin
      seen_addr <= per_addr;
      seen_we   <= per_we;
      if (per_we) begin
        mem_addr_reg <= per_addr;
        mem_data_reg <= per_wdata;
      end
    end
  end
endmodule : prat_per_model

`default_nettype wire

// File: prat_pkg.sv
// Shared constants and types of the peripheral register access path.
// Assumes a single ref_clk domain; slower peripheral rates are enables.
`default_nettype none

package prat_pkg;

  localparam int ADDR_W       = 32;
  localparam int DATA_W       = 32;
  localparam int BUS_N        = 6;
  localparam int IDX_W        = 3;
  localparam int CNT_W        = 4;
  localparam int PCLK_DIV_DEF = 4;

  // Address decode: I/O space top bits, per-bus page in addr[19:16]
  localparam logic [11:0] IO_TOP      = 12'h000;
  localparam logic [3:0]  BUS1_PAGE   = 4'h8;
  localparam logic [3:0]  BUS6_PAGE   = 4'hd;
  localparam logic [3:0]  PAGE_TO_IDX = 4'h7;
  localparam logic [7:0]  EXTBUS_PAGE = 8'h81;
  localparam logic [7:0]  BERR_LINE   = 8'h30;

  // Peripheral bus cycles per bus, entry 0 is bus 1
  localparam logic [BUS_N-1:0][CNT_W-1:0] BUS_CYC_DEF =
    {4'h2, 4'h2, 4'h2, 4'h2, 4'h2, 4'h2};

  typedef enum logic [2:0] {
    PRAT_IDLE = 3'h0,
    PRAT_MAIN = 3'h1,
    PRAT_SYNC = 3'h3,
    PRAT_PBUS = 3'h2,
    PRAT_STRB = 3'h6,
    PRAT_DONE = 3'h7
  } prat_state_type;

endpackage : prat_pkg

`default_nettype wire

// File: test_peripheral_register_access_timing.sv
// Self-checking bench for the register access sequencer.
// Assumes the responder model answers on the strobe side.
`default_nettype none

module test_peripheral_register_access_timing;
  timeunit 1ns;
  timeprecision 1ps;
  import prat_pkg::*;
  // Divider ratio under test and the default per-bus cycle count
  localparam int DIV  = 3;
  localparam int BCYC = int'(BUS_CYC_DEF[0]);
  logic              ref_clk, srst, core_req, core_we, xfer_req, core_wait, core_ack;
  logic              per_we, per_stb, seen_we;
  logic [31:0]       core_addr, core_wdata, core_rdata, per_addr, per_wdata;
  logic [31:0]       per_rdata, seen_addr, prev;
  logic [IDX_W-1:0]  per_bus;
  int                error_cnt = 0;
  int                checks_done = 0;
  int                cyc_cnt = 0;
  int                lat;

  prat_bridge #(.PCLK_DIV(DIV)) dut_u (
    .ref_clk(ref_clk), .srst(srst), .core_req(core_req), .core_we(core_we),
    .core_addr(core_addr), .core_wdata(core_wdata), .core_wait(core_wait),
    .core_ack(core_ack), .core_rdata(core_rdata), .xfer_req(xfer_req),
    .per_bus(per_bus), .per_addr(per_addr), .per_wdata(per_wdata),
    .per_we(per_we), .per_stb(per_stb), .per_rdata(per_rdata)
  );

  prat_per_model per_u (
    .ref_clk(ref_clk), .per_stb(per_stb), .per_we(per_we), .per_addr(per_addr),
    .per_wdata(per_wdata), .per_rdata(per_rdata), .seen_addr(seen_addr),
    .seen_we(seen_we)
  );

  always #2.5 ref_clk = ~ref_clk;

  task automatic close_out;
    $display("Checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : close_out

  always @(posedge ref_clk) begin
    cyc_cnt++;
    if (cyc_cnt == 3000) begin
      error_cnt++;
      close_out();
    end
  end

  task automatic chk_word(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_word

  task automatic chk_lat(input string what, input int lo, input int hi, input int got);
    checks_done++;
    if (got < lo || got > hi) begin
      error_cnt++;
      $display("[FAIL] %s expected %0d..%0d seen %0d", what, lo, hi, got);
    end
  endtask : chk_lat

  // Request stands until the ack edge; hold keeps it up for a back-to-back access.
  // Contention is raised after edge xfer_on and dropped after edge xfer_off.
  task automatic access(input logic we, input logic [31:0] addr, input logic [31:0] wd,
                        input int xfer_on, input int xfer_off, input bit hold,
                        output int n);
    core_req   = 1'b1;
    core_we    = we;
    core_addr  = addr;
    core_wdata = wd;
    n = 0;
    do begin
      @(posedge ref_clk);
      #1;
      n++;
      if (n == xfer_on) xfer_req = 1'b1;
      if (n == xfer_off) xfer_req = 1'b0;
    end while (core_ack !== 1'b1 && n < 40);
    chk_word("core_wait", 32'h0, {31'h0, core_wait});
    // A dropped request lets an edge pass, so the next one never flickers
    if (!hold) begin
      core_req = 1'b0;
      @(posedge ref_clk);
      #1;
    end
  endtask : access

  task automatic t_plain;
    access(1'b0, 32'h0008_1300, 32'h0, 0, 0, 1'b0, lat);
    chk_lat("bus error read cycles", 3 + BCYC, 3 + BCYC, lat);
    chk_word("read data", 32'h0008_1300 ^ 32'h5a5a_5a5a, core_rdata);
    chk_word("bus", 32'h1, {29'h0, per_bus});
    // Outside the I/O space: bus 1 with no sync cycles
    access(1'b0, 32'h0100_0040, 32'h0, 0, 0, 1'b0, lat);
    chk_lat("unmapped read cycles", 3 + BCYC, 3 + BCYC, lat);
    chk_word("unmapped bus", 32'h1, {29'h0, per_bus});
  endtask : t_plain

  // Synced: take, one slow cycle at most of main plus sync, bus cycles in slow cycles, strobe
  task automatic t_sync;
    for (int i = 2; i <= 6; i++) begin
      access(1'b0, {12'h0, 4'(i + 7), 16'h0010}, 32'h0, 0, 0, 1'b0, lat);
      chk_lat("synced read cycles", 3 + BCYC * DIV, 2 + DIV + BCYC * DIV, lat);
      chk_word("bus", 32'(i), {29'h0, per_bus});
    end
    access(1'b0, 32'h0008_1000, 32'h0, 0, 0, 1'b0, lat);
    chk_lat("ext control cycles", 3 + BCYC * DIV, 2 + DIV + BCYC * DIV, lat);
  endtask : t_sync

  task automatic t_xfer;
    // Transfer controller holds the bus for three cycles before the core gets it
    xfer_req = 1'b1;
    access(1'b0, 32'h0008_0020, 32'h0, 0, 3, 1'b0, lat);
    chk_lat("contended cycles", 6 + BCYC, 6 + BCYC, lat);
    // Contention in the peripheral phase freezes the count for two cycles
    access(1'b0, 32'h0008_0030, 32'h0, 2, 4, 1'b0, lat);
    chk_lat("stalled cycles", 5 + BCYC, 5 + BCYC, lat);
    chk_word("stalled read data", 32'h0008_0030 ^ 32'h5a5a_5a5a, core_rdata);
  endtask : t_xfer

  task automatic t_b2b;
    prev = core_rdata;
    access(1'b1, 32'h0008_0010, 32'h1234_abcd, 0, 0, 1'b1, lat);
    chk_lat("write cycles", 3 + BCYC, 3 + BCYC, lat);
    chk_word("rdata after write", prev, core_rdata);
    // Only the last written word is read back before use
    access(1'b0, 32'h0008_0010, 32'h0, 0, 0, 1'b0, lat);
    chk_lat("back to back cycles", 4 + BCYC, 4 + BCYC, lat);
    chk_word("readback", 32'h1234_abcd, core_rdata);
    chk_word("last strobe we", 32'h0, {31'h0, seen_we});
    chk_word("last strobe addr", 32'h0008_0010, seen_addr);
  endtask : t_b2b

  initial begin
    ref_clk    = 1'b0;
    srst       = 1'b1;
    core_req   = 1'b0;
    core_we    = 1'b0;
    core_addr  = 32'h0;
    core_wdata = 32'h0;
    xfer_req   = 1'b0;
    repeat (4) @(posedge ref_clk);
    #1;
    srst = 1'b0;
    @(posedge ref_clk);
    #1;
    t_plain();
    t_sync();
    t_xfer();
    t_b2b();
    close_out();
  end
endmodule : test_peripheral_register_access_timing

`default_nettype wire
